// ==== hw/smb_ctl_defines.svh ====
`ifndef SMB_CTL_DEFINES_SVH
`define SMB_CTL_DEFINES_SVH

// special-function address and pages of the two control registers
`define SMB_CTL_SFR_ADDR   8'hc0
`define SMB_CTL_PAGE_INST0 4'h0
`define SMB_CTL_PAGE_INST1 4'hf

// bit positions inside a control register
`define SMB_BIT_MASTER     3'h7
`define SMB_BIT_TXMODE     3'h6
`define SMB_BIT_START      3'h5
`define SMB_BIT_STOP       3'h4
`define SMB_BIT_ACKRQ      3'h3
`define SMB_BIT_ARBLOST    3'h2
`define SMB_BIT_ACK        3'h1
`define SMB_BIT_SI         3'h0

// reset value of a control register
`define SMB_CTL_RESET      8'h00

// crossing depth between the system and link domains
`define SMB_SYNC_STAGES    2

`endif

// ==== hw/smb_ctl_pkg.sv ====
package smb_ctl_pkg;

   // bus events reported by the link-side engine, one-cycle pulses
   typedef struct packed {
      logic start_det;
      logic start_gen;
      logic stop_det;
      logic stop_gen;
      logic byte_rx;
      logic byte_done;
      logic arb_lost;
      logic tx_set;
      logic tx_clr;
      logic ack_got;
      logic nack_got;
   } smb_evt_type;

   // state of one interface: the eight software-visible bits and the hidden ack_written
   typedef struct packed {
      logic master;
      logic txmode;
      logic start;
      logic stop;
      logic ackrq;
      logic arblost;
      logic ack;
      logic si;
      logic ack_written;
   } smb_ctl_type;

   // command levels handed from the system domain to the link domain
   typedef struct packed {
      logic hold;
      logic start;
      logic stop;
      logic master;
      logic ack_send;
      logic adv_tgl;
   } smb_xcmd_type;

   // what the link-side engine and the pins see
   typedef struct packed {
      logic scl_out;
      logic scl_oe;
      logic start_req;
      logic stop_req;
      logic stop_first;
      logic ack_send;
      logic advance;
   } smb_bus_cmd_type;

endpackage

// ==== hw/smb_link_side.sv ====
`timescale 1ns/1ps
`include "smb_ctl_defines.svh"

module smb_link_side
   import smb_ctl_pkg::*;
(
   // link domain
   input  wire logic            link_clock,
   input  wire logic            rst_b,
   // events from the bus engine
   input  wire smb_evt_type     bus_evt,
   output      smb_evt_type     evt_tgl,
   // commands from the system domain
   input  wire smb_xcmd_type    xcmd,
   output      smb_bus_cmd_type bus_cmd
);

   smb_evt_type     evt_tgl_reg;
   smb_xcmd_type    xcmd_s1_reg;
   smb_xcmd_type    xcmd_s2_reg;
   logic            adv_seen_reg;
   smb_bus_cmd_type bus_cmd_reg;
   smb_bus_cmd_type bus_cmd_next;
   wire  logic      adv_pulse;

   // every event becomes a toggle so no pulse is lost crossing over
   always_ff @(posedge link_clock or negedge rst_b) begin
      if (!rst_b) begin
         evt_tgl_reg <= smb_evt_type'(0);
      end else begin
         evt_tgl_reg <= smb_evt_type'(evt_tgl_reg ^ bus_evt);
      end
   end

   // first stage feeds the second only
   always_ff @(posedge link_clock or negedge rst_b) begin
      if (!rst_b) begin
         xcmd_s1_reg  <= smb_xcmd_type'(0);
         xcmd_s2_reg  <= smb_xcmd_type'(0);
         adv_seen_reg <= 1'b0;
         bus_cmd_reg  <= smb_bus_cmd_type'(0);
      end else begin
         xcmd_s1_reg  <= xcmd;
         xcmd_s2_reg  <= xcmd_s1_reg;
         adv_seen_reg <= xcmd_s2_reg.adv_tgl;
         bus_cmd_reg  <= bus_cmd_next;
      end
   end

   assign adv_pulse = xcmd_s2_reg.adv_tgl ^ adv_seen_reg;

   always_comb begin
      bus_cmd_next            = smb_bus_cmd_type'(0);
      bus_cmd_next.scl_out    = 1'b0;
      bus_cmd_next.scl_oe     = xcmd_s2_reg.hold;
      bus_cmd_next.start_req  = xcmd_s2_reg.start;
      bus_cmd_next.stop_req   = xcmd_s2_reg.stop & xcmd_s2_reg.master;
      // stop goes out first when both are pending as master
      bus_cmd_next.stop_first = xcmd_s2_reg.start & xcmd_s2_reg.stop
                                & xcmd_s2_reg.master;
      bus_cmd_next.ack_send   = xcmd_s2_reg.ack_send;
      bus_cmd_next.advance    = adv_pulse;
   end

   assign evt_tgl = evt_tgl_reg;
   assign bus_cmd = bus_cmd_reg;

endmodule

// ==== hw/smb_ctl.sv ====
`timescale 1ns/1ps
`include "smb_ctl_defines.svh"


module smb_ctl
   import smb_ctl_pkg::*;
#(
   parameter int N_INST = 2
)
(
   // system clock and reset
   input  wire logic                        clock,
   input  wire logic                        rst_b,
   // special-function register port
   input  wire logic [7:0]                  sfr_addr,
   input  wire logic [3:0]                  sfr_page,
   input  wire logic                        sfr_wr,
   input  wire logic                        sfr_bit_wr,
   input  wire logic [2:0]                  sfr_bit_idx,
   input  wire logic [7:0]                  sfr_wdata,
   input  wire logic                        sfr_rd,
   output      logic [7:0]                  sfr_rdata,
   // hardware acknowledge enable per instance
   input  wire logic [N_INST-1:0]           hw_ack_enable,
   // link domain
   input  wire logic                        link_clock,
   input  wire smb_evt_type [N_INST-1:0]     bus_evt,
   output      smb_bus_cmd_type [N_INST-1:0] bus_cmd
);

   // ------------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------------

   function automatic logic [7:0] ctl_byte(input smb_ctl_type c);
      ctl_byte = {c.master, c.txmode, c.start, c.stop,
                  c.ackrq, c.arblost, c.ack, c.si};
   endfunction

   function automatic logic si_event(input smb_evt_type e);
      si_event = e.start_gen | e.start_det | e.stop_det | e.stop_gen
                 | e.byte_done | e.arb_lost;
   endfunction

   // one step of a control register: hardware sets win over clears, except that a write to ack wins over ack_got
   function automatic smb_ctl_type ctl_next(
      input smb_ctl_type c,
      input smb_evt_type e,
      input logic [7:0]  wm,
      input logic [7:0]  wd,
      input logic        hwack
   );
      smb_ctl_type n;
      logic        si_clr;
      n      = c;
      si_clr = wm[`SMB_BIT_SI] & ~wd[`SMB_BIT_SI];

      if (e.start_gen) begin
         n.master = 1'b1;
      end else if (e.stop_gen | e.arb_lost) begin
         n.master = 1'b0;
      end

      if (e.start_gen | e.tx_set) begin
         n.txmode = 1'b1;
      end else if (e.start_det | e.arb_lost | e.tx_clr) begin
         n.txmode = 1'b0;
      end

      if (wm[`SMB_BIT_START]) begin
         n.start = wd[`SMB_BIT_START];
      end
      // not cleared once the start has gone out
      if (e.start_det | e.start_gen) begin
         n.start = 1'b1;
      end

      if (e.stop_gen) begin
         n.stop = 1'b0;
      end
      if (wm[`SMB_BIT_STOP]) begin
         n.stop = wd[`SMB_BIT_STOP];
      end
      if (e.stop_det) begin
         n.stop = 1'b1;
      end

      if (si_clr) begin
         n.ackrq = 1'b0;
      end
      // request unused when hardware answers on its own
      if (e.byte_rx & ~hwack) begin
         n.ackrq = 1'b1;
      end

      if (si_clr) begin
         n.arblost = 1'b0;
      end
      if (e.arb_lost) begin
         n.arblost = 1'b1;
      end

      if (e.ack_got) begin
         n.ack = 1'b1;
      end else if (e.nack_got) begin
         n.ack = 1'b0;
      end
      if (wm[`SMB_BIT_ACK]) begin
         n.ack = wd[`SMB_BIT_ACK];
      end

      // a fresh byte voids any earlier acknowledge write
      if (wm[`SMB_BIT_ACK]) begin
         n.ack_written = 1'b1;
      end else if (e.byte_rx) begin
         n.ack_written = 1'b0;
      end

      if (wm[`SMB_BIT_SI]) begin
         n.si = wd[`SMB_BIT_SI];
      end
      // an event in the clearing cycle keeps the flag up
      if (si_event(e)) begin
         n.si = 1'b1;
      end
      ctl_next = n;
   endfunction

   // ------------------------------------------------------------------
   // register port decode
   // ------------------------------------------------------------------

   wire logic              addr_hit;
   wire logic [N_INST-1:0] page_hit;
   wire logic [7:0]        bit_mask;
   wire logic [7:0]        wr_mask;
   wire logic [7:0]        wr_data;
   wire logic [7:0]        rd_sel;

   assign addr_hit    = (sfr_addr == `SMB_CTL_SFR_ADDR);
   assign page_hit[0] = addr_hit & (sfr_page == `SMB_CTL_PAGE_INST0);
   assign page_hit[1] = addr_hit & (sfr_page == `SMB_CTL_PAGE_INST1);
   assign bit_mask    = 8'h01 << sfr_bit_idx;
   // bit writes touch one bit only, except that clearing si also clears ackrq and arblost
   assign wr_mask     = sfr_wr ? 8'hff : (sfr_bit_wr ? bit_mask : 8'h00);
   assign wr_data     = sfr_wr ? sfr_wdata : {8{sfr_wdata[0]}};

   // ------------------------------------------------------------------
   // per-instance state, crossing and link logic
   // ------------------------------------------------------------------

   smb_ctl_type  ctl_reg  [N_INST];
   smb_ctl_type  ctl_next_w [N_INST];
   smb_xcmd_type xcmd_reg [N_INST];
   smb_xcmd_type xcmd_next [N_INST];
   logic [7:0]   rd_byte [N_INST];

   genvar i;
   generate
      for (i = 0; i < N_INST; i++) begin : g_inst
         smb_evt_type evt_tgl;
         smb_evt_type evt_s1_reg;
         smb_evt_type evt_s2_reg;
         smb_evt_type evt_s3_reg;
         smb_evt_type evt_pulse;
         wire logic [7:0] inst_mask;
         wire logic       si_clr;

         // each copy decodes its own page only
         assign inst_mask = page_hit[i] ? wr_mask : 8'h00;
         assign si_clr    = inst_mask[`SMB_BIT_SI] & ~wr_data[`SMB_BIT_SI]
                            & ctl_reg[i].si;

         always_ff @(posedge clock or negedge rst_b) begin
            if (!rst_b) begin
               evt_s1_reg <= smb_evt_type'(0);
               evt_s2_reg <= smb_evt_type'(0);
               evt_s3_reg <= smb_evt_type'(0);
            end else begin
               evt_s1_reg <= evt_tgl;
               evt_s2_reg <= evt_s1_reg;
               evt_s3_reg <= evt_s2_reg;
            end
         end

         assign evt_pulse = smb_evt_type'(evt_s2_reg ^ evt_s3_reg);

         assign ctl_next_w[i] = ctl_next(ctl_reg[i], evt_pulse, inst_mask,
                                         wr_data, hw_ack_enable[i]);

         always_ff @(posedge clock or negedge rst_b) begin
            if (!rst_b) begin
               ctl_reg[i]  <= smb_ctl_type'(0);
               xcmd_reg[i] <= smb_xcmd_type'(0);
            end else begin
               ctl_reg[i]  <= ctl_next_w[i];
               xcmd_reg[i] <= xcmd_next[i];
            end
         end

         always_comb begin
            xcmd_next[i]          = xcmd_reg[i];
            xcmd_next[i].hold     = ctl_next_w[i].si;
            xcmd_next[i].start    = ctl_next_w[i].start;
            xcmd_next[i].stop     = ctl_next_w[i].stop;
            xcmd_next[i].master   = ctl_next_w[i].master;
            // judged before the clear drops the request; held with the advance
            if (si_clr) begin
               xcmd_next[i].ack_send = ctl_reg[i].ack
                                       & ~(ctl_reg[i].ackrq
                                           & ~ctl_reg[i].ack_written);
               xcmd_next[i].adv_tgl  = ~xcmd_reg[i].adv_tgl;
            end
         end

         assign rd_byte[i] = ctl_byte(ctl_reg[i]);

         smb_link_side u_link (
            .link_clock (link_clock),
            .rst_b      (rst_b),
            .bus_evt    (bus_evt[i]),
            .evt_tgl    (evt_tgl),
            .xcmd       (xcmd_reg[i]),
            .bus_cmd    (bus_cmd[i])
         );
      end
   endgenerate

   // ------------------------------------------------------------------
   // read port
   // ------------------------------------------------------------------

   logic [7:0] rdata_reg;

   // unmapped address or page reads as zero
   assign rd_sel = page_hit[0] ? rd_byte[0] :
                   (page_hit[1] ? rd_byte[1] : 8'h00);

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rdata_reg <= `SMB_CTL_RESET;
      end else if (sfr_rd) begin
         rdata_reg <= rd_sel;
      end
   end

   assign sfr_rdata = rdata_reg;

endmodule

// ==== testbench/smb_ctl_sva.sv ====
`timescale 1ns/1ps

module smb_ctl_sva
   import smb_ctl_pkg::*;
#(
   parameter int N_INST = 2
)
(
   // system side
   input wire logic                         clock,
   input wire logic                         rst_b,
   input wire logic [7:0]                   sfr_addr,
   input wire logic [3:0]                   sfr_page,
   input wire logic                         sfr_rd,
   input wire logic [7:0]                   sfr_rdata,
   // link side
   input wire logic                         link_clock,
   input wire smb_evt_type [N_INST-1:0]     bus_evt,
   input wire smb_bus_cmd_type [N_INST-1:0] bus_cmd
);
   a_bad_addr_zero: assert property (@(posedge clock) disable iff (!rst_b)
      sfr_rd && sfr_addr != 8'hc0 |=> sfr_rdata == 8'h00)
      else $error("unmapped address read not zero");
   a_bad_page_zero: assert property (@(posedge clock) disable iff (!rst_b)
      sfr_rd && sfr_page != 4'h0 && sfr_page != 4'hf |=> sfr_rdata == 8'h00)
      else $error("unmapped page read not zero");
   a_rdata_stands: assert property (@(posedge clock) disable iff (!rst_b)
      !sfr_rd |=> $stable(sfr_rdata))
      else $error("read data changed without a read");
   a_scl_out_low: assert property (@(posedge link_clock) disable iff (!rst_b)
      bus_cmd[0].scl_out == 1'b0 && bus_cmd[1].scl_out == 1'b0)
      else $error("clock line driven high");
   a_stop_then_start: assert property (@(posedge link_clock) disable iff (!rst_b)
      bus_cmd[0].stop_first |-> bus_cmd[0].start_req && bus_cmd[0].stop_req)
      else $error("stop first without both requests");
   a_advance_pulse: assert property (@(posedge link_clock) disable iff (!rst_b)
      bus_cmd[0].advance |=> !bus_cmd[0].advance)
      else $error("advance longer than one cycle");
   a_advance_release: assert property (@(posedge link_clock) disable iff (!rst_b)
      $rose(bus_cmd[0].advance) |-> ##[0:4] !bus_cmd[0].scl_oe)
      else $error("advance without clock release");
   a_event_stalls0: assert property (@(posedge link_clock) disable iff (!rst_b)
      bus_evt[0].byte_done |-> ##[1:30] bus_cmd[0].scl_oe)
      else $error("byte event did not stall interface 0");
   a_event_stalls1: assert property (@(posedge link_clock) disable iff (!rst_b)
      bus_evt[1].byte_done |-> ##[1:30] bus_cmd[1].scl_oe)
      else $error("byte event did not stall interface 1");
   c_advance: cover property (@(posedge link_clock) bus_cmd[0].advance);
   c_stop_first: cover property (@(posedge link_clock) bus_cmd[0].stop_first);
   c_stall1: cover property (@(posedge link_clock) bus_cmd[1].scl_oe);
endmodule

// ==== testbench/smb_bus_model.sv ====
`timescale 1ns/1ps

module smb_bus_model
   import smb_ctl_pkg::*;
(
   // link side of both interfaces
   input  wire logic                  link_clock,
   input  wire logic                  rst_b,
   input  wire smb_bus_cmd_type [1:0] bus_cmd,
   output      smb_evt_type     [1:0] bus_evt
);
   logic [1:0] last_ack;
   logic       stop_first_seen;
   initial bus_evt = '0;
   // a stalled interface produces no bus events at all
   task automatic send(input int i, input smb_evt_type e);
      @(negedge link_clock);
      while (bus_cmd[i].scl_oe !== 1'b0) @(negedge link_clock);
      bus_evt[i] = e;
      @(negedge link_clock);
      bus_evt[i] = '0;
   endtask
   always @(posedge link_clock or negedge rst_b) begin
      if (!rst_b) begin
         last_ack        <= 2'b11;
         stop_first_seen <= 1'b0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (bus_cmd[i].advance) last_ack[i] <= bus_cmd[i].ack_send;
         end
         if (bus_cmd[0].stop_first) stop_first_seen <= 1'b1;
      end
   end
endmodule

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps

module testbench
   import smb_ctl_pkg::*;
;
   logic                  clock = 1'b0;
   logic                  link_clock = 1'b0;
   logic                  rst_b = 1'b0;
   logic [7:0]            sfr_addr, sfr_wdata, sfr_rdata;
   logic [3:0]            sfr_page;
   logic                  sfr_wr, sfr_bit_wr, sfr_rd;
   logic [2:0]            sfr_bit_idx;
   logic [1:0]            hw_ack_enable;
   smb_evt_type     [1:0] bus_evt;
   smb_bus_cmd_type [1:0] bus_cmd;
   int                    fails = 0;
   int                    cmp_count = 0;
   int                    cycles = 0;

   always #20 clock = ~clock;
   always #7.5 link_clock = ~link_clock;

   smb_ctl #(.N_INST(2)) u_smb_ctl (.clock(clock), .rst_b(rst_b), .sfr_addr(sfr_addr),
      .sfr_page(sfr_page), .sfr_wr(sfr_wr), .sfr_bit_wr(sfr_bit_wr),
      .sfr_bit_idx(sfr_bit_idx), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd),
      .sfr_rdata(sfr_rdata), .hw_ack_enable(hw_ack_enable), .link_clock(link_clock),
      .bus_evt(bus_evt), .bus_cmd(bus_cmd));
   smb_bus_model u_smb_bus_model (.link_clock(link_clock), .rst_b(rst_b),
      .bus_cmd(bus_cmd), .bus_evt(bus_evt));

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] pg, input logic [7:0] d);
      @(negedge clock);
      {sfr_addr, sfr_page, sfr_wdata, sfr_wr} = {8'hc0, pg, d, 1'b1};
      @(negedge clock);
      sfr_wr = 1'b0;
   endtask
   task automatic bwr(input logic [3:0] pg, input logic [2:0] idx, input logic b);
      @(negedge clock);
      {sfr_addr, sfr_page, sfr_bit_idx, sfr_wdata, sfr_bit_wr} = {8'hc0, pg, idx, 7'h0, b, 1'b1};
      @(negedge clock);
      sfr_bit_wr = 1'b0;
   endtask
   task automatic chk_reg(input logic [7:0] a, input logic [3:0] pg,
                          input logic [7:0] m, input logic [7:0] e);
      @(negedge clock);
      {sfr_addr, sfr_page, sfr_rd} = {a, pg, 1'b1};
      @(negedge clock);
      sfr_rd = 1'b0;
      check(sfr_rdata & m, e);
   endtask
   task automatic evt(input int i, input smb_evt_type e);
      u_smb_bus_model.send(i, e);
      repeat (10) @(negedge clock);
   endtask
   task automatic clr_si(input logic [3:0] pg);
      bwr(pg, 3'h0, 1'b0);
      repeat (6) @(negedge clock);
   endtask

   task automatic s_reset;
      chk_reg(8'hc0, 4'h0, 8'hff, 8'h00);
      chk_reg(8'hc0, 4'hf, 8'hff, 8'h00);
      chk_reg(8'hc1, 4'h0, 8'hff, 8'h00);
      chk_reg(8'hc0, 4'h3, 8'hff, 8'h00);
   endtask
   task automatic s_write;
      wr(4'h0, 8'hff);
      chk_reg(8'hc0, 4'h0, 8'hff, 8'h33);
      chk_reg(8'hc0, 4'hf, 8'hff, 8'h00);
      check({7'h0, bus_cmd[0].scl_oe}, 8'h01);
      check({7'h0, bus_cmd[0].start_req}, 8'h01);
      wr(4'h0, 8'h00);
      repeat (6) @(negedge clock);
      check({7'h0, bus_cmd[0].scl_oe}, 8'h00);
      bwr(4'h0, 3'h5, 1'b1);
      chk_reg(8'hc0, 4'h0, 8'hff, 8'h20);
      bwr(4'h0, 3'h5, 1'b0);
   endtask
   task automatic s_arb;
      evt(0, '{start_gen: 1'b1, default: 1'b0});
      repeat (40) @(negedge clock);
      chk_reg(8'hc0, 4'h0, 8'h81, 8'h81);
      clr_si(4'h0);
      evt(0, '{arb_lost: 1'b1, default: 1'b0});
      chk_reg(8'hc0, 4'h0, 8'h85, 8'h05);
      clr_si(4'h0);
      chk_reg(8'hc0, 4'h0, 8'h85, 8'h00);
   endtask
   task automatic s_ack;
      bwr(4'h0, 3'h1, 1'b1);
      evt(0, '{byte_rx: 1'b1, byte_done: 1'b1, default: 1'b0});
      chk_reg(8'hc0, 4'h0, 8'h09, 8'h09);
      clr_si(4'h0);
      check({7'h0, u_smb_bus_model.last_ack[0]}, 8'h00);
      evt(0, '{byte_rx: 1'b1, byte_done: 1'b1, default: 1'b0});
      bwr(4'h0, 3'h1, 1'b1);
      clr_si(4'h0);
      check({7'h0, u_smb_bus_model.last_ack[0]}, 8'h01);
      @(negedge clock);
      hw_ack_enable = 2'b01;
      evt(0, '{byte_rx: 1'b1, byte_done: 1'b1, default: 1'b0});
      chk_reg(8'hc0, 4'h0, 8'h09, 8'h01);
      clr_si(4'h0);
      @(negedge clock);
      hw_ack_enable = 2'b00;
   endtask
   task automatic s_stop;
      evt(0, '{start_gen: 1'b1, default: 1'b0});
      clr_si(4'h0);
      wr(4'h0, 8'h30);
      repeat (10) @(negedge clock);
      check({7'h0, u_smb_bus_model.stop_first_seen}, 8'h01);
      check({7'h0, bus_cmd[0].start_req}, 8'h01);
      evt(0, '{stop_gen: 1'b1, default: 1'b0});
      chk_reg(8'hc0, 4'h0, 8'h91, 8'h01);
      wr(4'h0, 8'h00);
      repeat (6) @(negedge clock);
      evt(0, '{stop_det: 1'b1, start_det: 1'b1, default: 1'b0});
      chk_reg(8'hc0, 4'h0, 8'hb1, 8'h31);
      clr_si(4'h0);
   endtask
   task automatic s_inst1;
      evt(1, '{byte_done: 1'b1, default: 1'b0});
      chk_reg(8'hc0, 4'hf, 8'h01, 8'h01);
      chk_reg(8'hc0, 4'h0, 8'h01, 8'h00);
      check({6'h0, bus_cmd[1].scl_oe, bus_cmd[0].scl_oe}, 8'h02);
      clr_si(4'hf);
      chk_reg(8'hc0, 4'hf, 8'h01, 8'h00);
   endtask

   // ceiling well above the few hundred cycles the scenarios need
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         final_report;
      end
   end

   initial begin
      {sfr_addr, sfr_wdata, sfr_page, sfr_wr, sfr_bit_wr, sfr_rd, sfr_bit_idx} = '0;
      hw_ack_enable = 2'b00;
      repeat (3) @(negedge clock);
      rst_b = 1'b1;
      s_reset;
      s_write;
      s_arb;
      s_ack;
      s_stop;
      s_inst1;
      final_report;
   end
endmodule

bind smb_ctl smb_ctl_sva #(.N_INST(N_INST)) u_smb_ctl_sva (.clock(clock), .rst_b(rst_b),
   .sfr_addr(sfr_addr), .sfr_page(sfr_page), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
   .link_clock(link_clock), .bus_evt(bus_evt), .bus_cmd(bus_cmd));
